// File: lias_pkg.sv
// lias_pkg: constants, field positions and carrier types of the per-channel
// alarm and error interrupt status block.
// assumes one register bus clock; detectors deliver live status and events on that clock.
//
// Operation
// - system alarm flag bit 7 sets on rise, or any edge when alarm select set.
// - line alarm flag bit 6 sets on rise, or any edge when alarm select set.
// - pattern sync flag bit 5 sets on rise, or any edge when its select set.
// - loop activate flag bit 1 sets on rise, or any edge when code select set.
// - loop deactivate flag bit 0 sets on rise, or any edge when code select set.
// - all flags reset to zero; writing one clears a bit, zero leaves it.
// - any set flag drives the interrupt output active.
// - system bipolar violation event latches into second register bit 5.
// - line bipolar violation event latches into second register bit 4.
// - system excess zeros event latches into second register bit 3.
// - line excess zeros event latches into second register bit 2.
// - any pattern bit error latches into second register bit 1.
// - sixteen bit error counter overflow sets second register bit 0.
// - low byte register shows low eight bits of the captured error count.
// - counter registers update automatically or on request, per mode bit 1.
// - register set repeats per channel 0 to 14, spaced 40H apart.
// - live pattern sync reads one while in sync, zero while out.
package lias_pkg;

   localparam int          ADDR_W       = 11;
   localparam int          CH_SHIFT     = 6;
   localparam logic [5:0]  OFS_FLAGS1   = 6'h21;
   localparam logic [5:0]  OFS_FLAGS2   = 6'h22;
   localparam logic [5:0]  OFS_CNT_LO   = 6'h23;
   localparam logic [5:0]  OFS_CNT_HI   = 6'h24;
   localparam logic [5:0]  OFS_EDGE_SEL = 6'h2A;
   localparam logic [5:0]  OFS_ERR_CFG  = 6'h2B;

   // first flag register
   localparam int          B1_SYS_ALARM   = 7;
   localparam int          B1_LINE_ALARM  = 6;
   localparam int          B1_PATTERN     = 5;
   localparam int          B1_LOOP_ACT    = 1;
   localparam int          B1_LOOP_DEACT  = 0;
   localparam logic [7:0]  FLAGS1_MASK    = 8'hE3;
   // second flag register
   localparam int          B2_SYS_BPV     = 5;
   localparam int          B2_LINE_BPV    = 4;
   localparam int          B2_SYS_EXZ     = 3;
   localparam int          B2_LINE_EXZ    = 2;
   localparam int          B2_PATTERN_ERR = 1;
   localparam int          B2_OVERFLOW    = 0;
   localparam logic [7:0]  FLAGS2_MASK    = 8'h3F;
   // edge select register
   localparam int          BE_ALARM       = 6;
   localparam int          BE_PATTERN     = 5;
   localparam int          BE_LOOP_CODE   = 0;
   localparam logic [7:0]  EDGE_SEL_MASK  = 8'h61;
   // error configuration register
   localparam int          BC_MODE        = 1;
   localparam int          BC_UPDATE_REQ  = 0;
   localparam logic [7:0]  ERR_CFG_MASK   = 8'h02;

   localparam logic [7:0]  RST_BYTE       = 8'h00;
   localparam logic [15:0] RST_COUNT      = 16'h0000;
   localparam logic [15:0] COUNT_MAX      = 16'hFFFF;
   localparam logic [4:0]  RST_LIVE       = 5'h00;

   typedef struct packed {
      logic sys_alarm_live;
      logic line_alarm_live;
      logic pattern_sync_live;
      logic loop_activate_live;
      logic loop_deactivate_live;
   } lias_live_t;

   typedef struct packed {
      logic sys_bpv;
      logic line_bpv;
      logic sys_exz;
      logic line_exz;
      logic pattern_err;
      logic err_inc;
   } lias_evt_t;

endpackage : lias_pkg

// File: lias_top.sv
// lias_top: latched interrupt status, edge selects and error counter of all channels.
// assumes live status and event pulses arrive synchronous to i_mclk from the detectors.
`timescale 1ns/1ps
module lias_top
   import lias_pkg::*;
#(
   parameter int NUM_CH = 15
) (
   input  wire logic              i_mclk,
   input  wire logic              i_rst_n,
   input  wire logic [ADDR_W-1:0] i_addr,
   input  wire logic [7:0]        i_wdata,
   input  wire logic              i_wr,
   input  wire logic              i_rd,
   input  wire lias_live_t        i_live [NUM_CH],
   input  wire lias_evt_t         i_evt  [NUM_CH],
   input  wire logic              i_count_tick,
   output logic [7:0]             o_rdata,
   output logic                   o_irq
);

   // ----------------------------------------------------------------
   // reset release
   // ----------------------------------------------------------------
   logic rst_meta_n;
   logic rst_n;

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rst_meta_n <= 1'b0;
         rst_n      <= 1'b0;
      end else begin
         rst_meta_n <= 1'b1;
         rst_n      <= rst_meta_n;
      end
   end

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   logic [ADDR_W-CH_SHIFT-1:0] sel_ch;
   logic [5:0]                 sel_ofs;

   assign sel_ch  = i_addr[ADDR_W-1:CH_SHIFT];
   assign sel_ofs = i_addr[CH_SHIFT-1:0];

   logic [NUM_CH-1:0][7:0] rd_word;
   logic [NUM_CH-1:0]      any_flag;

   // ----------------------------------------------------------------
   // per channel status
   // ----------------------------------------------------------------
   for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
      logic [7:0]  flags1;
      logic [7:0]  flags2;
      logic [7:0]  edge_sel;
      logic [7:0]  err_cfg;
      logic [15:0] count;
      logic [15:0] captured;
      logic [4:0]  prev_live;
      logic [7:0]  next_flags1;
      logic [7:0]  next_flags2;
      logic [7:0]  next_edge_sel;
      logic [7:0]  next_err_cfg;
      logic [15:0] next_count;
      logic [15:0] next_captured;
      logic [4:0]  live;
      logic [4:0]  rise;
      logic [4:0]  change;
      logic [7:0]  set1;
      logic [7:0]  set2;
      logic [7:0]  clr1;
      logic [7:0]  clr2;
      logic        hit;
      logic        update;
      logic        overflow;
      logic [7:0]  word;

      assign live = i_live[ch];
      assign hit  = (sel_ch == (ADDR_W-CH_SHIFT)'(ch));

      always_comb begin
         rise   = live & ~prev_live;
         change = live ^ prev_live;
         set1   = RST_BYTE;
         set2   = RST_BYTE;
         clr1   = RST_BYTE;
         clr2   = RST_BYTE;
         set1[B1_SYS_ALARM]  = edge_sel[BE_ALARM] ? change[4] : rise[4];
         set1[B1_LINE_ALARM] = edge_sel[BE_ALARM] ? change[3] : rise[3];
         // in sync reads one, so a rise marks gaining sync
         set1[B1_PATTERN]    = edge_sel[BE_PATTERN] ? change[2] : rise[2];
         set1[B1_LOOP_ACT]   = edge_sel[BE_LOOP_CODE] ? change[1] : rise[1];
         set1[B1_LOOP_DEACT] = edge_sel[BE_LOOP_CODE] ? change[0] : rise[0];
         overflow = i_evt[ch].err_inc && (count == COUNT_MAX);
         set2[B2_SYS_BPV]     = i_evt[ch].sys_bpv;
         set2[B2_LINE_BPV]    = i_evt[ch].line_bpv;
         set2[B2_SYS_EXZ]     = i_evt[ch].sys_exz;
         set2[B2_LINE_EXZ]    = i_evt[ch].line_exz;
         set2[B2_PATTERN_ERR] = i_evt[ch].pattern_err;
         set2[B2_OVERFLOW]    = overflow;
         if (i_wr && hit && (sel_ofs == OFS_FLAGS1)) begin
            clr1 = i_wdata;
         end
         if (i_wr && hit && (sel_ofs == OFS_FLAGS2)) begin
            clr2 = i_wdata;
         end
         // set is applied after clear so a coinciding event survives
         next_flags1 = ((flags1 & ~clr1) | set1) & FLAGS1_MASK;
         next_flags2 = ((flags2 & ~clr2) | set2) & FLAGS2_MASK;
         next_edge_sel = edge_sel;
         next_err_cfg  = err_cfg;
         if (i_wr && hit && (sel_ofs == OFS_EDGE_SEL)) begin
            next_edge_sel = i_wdata & EDGE_SEL_MASK;
         end
         if (i_wr && hit && (sel_ofs == OFS_ERR_CFG)) begin
            next_err_cfg = i_wdata & ERR_CFG_MASK;
         end
         // mode one follows the period tick, mode zero a software request
         update = err_cfg[BC_MODE] ? i_count_tick
                : (i_wr && hit && (sel_ofs == OFS_ERR_CFG) && i_wdata[BC_UPDATE_REQ]);
         next_captured = update ? count : captured;
         if (update) begin
            next_count = i_evt[ch].err_inc ? 16'h0001 : RST_COUNT;
         end else if (i_evt[ch].err_inc) begin
            next_count = count + 16'h0001;
         end else begin
            next_count = count;
         end
      end

      always_ff @(posedge i_mclk or negedge rst_n) begin
         if (!rst_n) begin
            flags1    <= RST_BYTE;
            flags2    <= RST_BYTE;
            edge_sel  <= RST_BYTE;
            err_cfg   <= RST_BYTE;
            count     <= RST_COUNT;
            captured  <= RST_COUNT;
            prev_live <= RST_LIVE;
         end else begin
            flags1    <= next_flags1;
            flags2    <= next_flags2;
            edge_sel  <= next_edge_sel;
            err_cfg   <= next_err_cfg;
            count     <= next_count;
            captured  <= next_captured;
            prev_live <= live;
         end
      end

      always_comb begin
         case (sel_ofs)
            OFS_FLAGS1:   word = flags1;
            OFS_FLAGS2:   word = flags2;
            OFS_CNT_LO:   word = captured[7:0];
            OFS_CNT_HI:   word = captured[15:8];
            OFS_EDGE_SEL: word = edge_sel;
            OFS_ERR_CFG:  word = err_cfg;
            default:      word = RST_BYTE;
         endcase
      end

      assign rd_word[ch]  = word;
      assign any_flag[ch] = (|flags1) || (|flags2);

      // ----------------------------------------------------------------
      // checks
      // ----------------------------------------------------------------
      sequence s_rd_low;
         i_rd && hit && (sel_ofs == OFS_CNT_LO);
      endsequence

      sequence s_auto_update;
         err_cfg[BC_MODE] && i_count_tick;
      endsequence

      sequence s_manual_req;
         !err_cfg[BC_MODE] && i_wr && hit && (sel_ofs == OFS_ERR_CFG) && i_wdata[BC_UPDATE_REQ];
      endsequence

      property p_sys_alarm_rise;
         @(posedge i_mclk) disable iff (!rst_n)
         $rose(i_live[ch].sys_alarm_live) |=> flags1[B1_SYS_ALARM];
      endproperty
      a_sys_alarm_rise: assert property (p_sys_alarm_rise)
         else $error("system alarm rise not latched");

      property p_sys_alarm_fall;
         @(posedge i_mclk) disable iff (!rst_n)
         $fell(i_live[ch].sys_alarm_live) && !edge_sel[BE_ALARM] && !flags1[B1_SYS_ALARM]
            && !$rose(i_live[ch].line_alarm_live) |=> !flags1[B1_SYS_ALARM];
      endproperty
      a_sys_alarm_fall: assert property (p_sys_alarm_fall)
         else $error("system alarm fall set flag in rise mode");

      property p_line_alarm_any;
         @(posedge i_mclk) disable iff (!rst_n)
         $changed(i_live[ch].line_alarm_live) && edge_sel[BE_ALARM] |=> flags1[B1_LINE_ALARM];
      endproperty
      a_line_alarm_any: assert property (p_line_alarm_any)
         else $error("line alarm edge not latched");

      property p_pattern_sync;
         @(posedge i_mclk) disable iff (!rst_n)
         ($rose(i_live[ch].pattern_sync_live)
            || ($fell(i_live[ch].pattern_sync_live) && edge_sel[BE_PATTERN]))
            |=> flags1[B1_PATTERN];
      endproperty
      a_pattern_sync: assert property (p_pattern_sync)
         else $error("pattern sync edge not latched");

      property p_loop_act;
         @(posedge i_mclk) disable iff (!rst_n)
         $fell(i_live[ch].loop_activate_live) && edge_sel[BE_LOOP_CODE]
            |=> flags1[B1_LOOP_ACT];
      endproperty
      a_loop_act: assert property (p_loop_act)
         else $error("loop activate edge not latched");

      property p_loop_deact;
         @(posedge i_mclk) disable iff (!rst_n)
         $rose(i_live[ch].loop_deactivate_live) |=> flags1[B1_LOOP_DEACT];
      endproperty
      a_loop_deact: assert property (p_loop_deact)
         else $error("loop deactivate rise not latched");

      property p_w1c;
         @(posedge i_mclk) disable iff (!rst_n)
         (clr2[B2_SYS_BPV] && !set2[B2_SYS_BPV]) |=> !flags2[B2_SYS_BPV];
      endproperty
      a_w1c: assert property (p_w1c)
         else $error("write one did not clear flag");

      property p_set_wins;
         @(posedge i_mclk) disable iff (!rst_n)
         (|(clr1 & set1)) || (|(clr2 & set2))
            |=> ((flags1 & $past(set1)) == $past(set1))
               && ((flags2 & $past(set2)) == $past(set2));
      endproperty
      a_set_wins: assert property (p_set_wins)
         else $error("clear beat a coinciding set");

      property p_events;
         @(posedge i_mclk) disable iff (!rst_n)
         i_evt[ch].line_exz ##1 1'b1 |-> flags2[B2_LINE_EXZ] ##1 o_irq;
      endproperty
      a_events: assert property (p_events)
         else $error("event not latched or not reported");

      property p_sys_bpv;
         @(posedge i_mclk) disable iff (!rst_n)
         i_evt[ch].sys_bpv |=> flags2[B2_SYS_BPV];
      endproperty
      a_sys_bpv: assert property (p_sys_bpv)
         else $error("system bipolar violation not latched");

      property p_overflow;
         @(posedge i_mclk) disable iff (!rst_n)
         i_evt[ch].err_inc && (count == COUNT_MAX) && !update
            |=> flags2[B2_OVERFLOW] && (count == RST_COUNT);
      endproperty
      a_overflow: assert property (p_overflow)
         else $error("counter overflow not flagged");

      property p_auto_update;
         @(posedge i_mclk) disable iff (!rst_n)
         s_auto_update |=> (captured == $past(count));
      endproperty
      a_auto_update: assert property (p_auto_update)
         else $error("automatic counter update missed");

      property p_manual_update;
         @(posedge i_mclk) disable iff (!rst_n)
         s_manual_req |=> (captured == $past(count)) && (count <= 16'h0001);
      endproperty
      a_manual_update: assert property (p_manual_update)
         else $error("manual counter update missed");

      property p_rd_low;
         @(posedge i_mclk) disable iff (!rst_n)
         s_rd_low |=> (o_rdata == $past(captured[7:0]));
      endproperty
      a_rd_low: assert property (p_rd_low)
         else $error("low byte read wrong");

      property p_reserved;
         @(posedge i_mclk) disable iff (!rst_n)
         (flags1 & ~FLAGS1_MASK) == RST_BYTE && (flags2 & ~FLAGS2_MASK) == RST_BYTE;
      endproperty
      a_reserved: assert property (p_reserved)
         else $error("reserved flag bit set");
   end

   // ----------------------------------------------------------------
   // read data and interrupt
   // ----------------------------------------------------------------
   logic [7:0] next_rdata;
   logic       next_irq;

   always_comb begin
      next_rdata = RST_BYTE;
      // channel field selects the copy; unmapped channels read zero
      if (i_rd && (sel_ch < (ADDR_W-CH_SHIFT)'(NUM_CH))) begin
         next_rdata = rd_word[sel_ch];
      end
      next_irq = |any_flag;
   end

   always_ff @(posedge i_mclk or negedge rst_n) begin
      if (!rst_n) begin
         o_rdata <= RST_BYTE;
         o_irq   <= 1'b0;
      end else begin
         o_rdata <= next_rdata;
         o_irq   <= next_irq;
      end
   end

   sequence s_all_clear;
      !(|any_flag);
   endsequence

   property p_irq_drop;
      @(posedge i_mclk) disable iff (!rst_n)
      s_all_clear |=> !o_irq;
   endproperty
   a_irq_drop: assert property (p_irq_drop)
      else $error("interrupt stayed high with no flags");

   property p_irq_set;
      @(posedge i_mclk) disable iff (!rst_n)
      (|any_flag) |=> o_irq;
   endproperty
   a_irq_set: assert property (p_irq_set)
      else $error("interrupt not raised");

   property p_absent_ch;
      @(posedge i_mclk) disable iff (!rst_n)
      i_rd && (sel_ch >= (ADDR_W-CH_SHIFT)'(NUM_CH)) |=> (o_rdata == RST_BYTE);
   endproperty
   a_absent_ch: assert property (p_absent_ch)
      else $error("absent channel read not zero");

endmodule : lias_top

// File: lias_host.sv
// lias_host: host processor model, master of the register bus of the status block.
// assumes single-cycle strobes and read data standing only in the cycle after the strobe.
`timescale 1ns/1ps
module lias_host
   import lias_pkg::*;
(
   input  wire logic              i_mclk,
   input  wire logic [7:0]        i_rdata,
   output logic [ADDR_W-1:0]      o_addr,
   output logic [7:0]             o_wdata,
   output logic                   o_wr,
   output logic                   o_rd
);
   initial begin
      o_addr  = '0;
      o_wdata = 8'h00;
      o_wr    = 1'b0;
      o_rd    = 1'b0;
   end

   // a one written to a flag position clears it
   task automatic bus_write(input logic [ADDR_W-1:0] addr, input logic [7:0] data);
      @(posedge i_mclk);
      o_addr  <= addr;
      o_wdata <= data;
      o_wr    <= 1'b1;
      @(posedge i_mclk);
      o_wr    <= 1'b0;
   endtask : bus_write

   task automatic bus_read(input logic [ADDR_W-1:0] addr, output logic [7:0] data);
      @(posedge i_mclk);
      o_addr <= addr;
      o_rd   <= 1'b1;
      @(posedge i_mclk);
      o_rd   <= 1'b0;
      #1;
      data = i_rdata;
   endtask : bus_read

   // both bytes fetched right after a capture, before the next one overwrites them
   task automatic read_count(input logic [4:0] ch, output logic [15:0] value);
      bus_read({ch, OFS_CNT_LO}, value[7:0]);
      bus_read({ch, OFS_CNT_HI}, value[15:8]);
   endtask : read_count
endmodule : lias_host

// File: lias_top_test.sv
// lias_top_test: self-checking bench of the alarm and error interrupt status block.
// assumes the host model drives the register bus; the bench drives live status and events.
`timescale 1ns/1ps
module lias_top_test
   import lias_pkg::*;
;
   localparam int     NCH = 15;
   logic              mclk = 1'b0;
   logic              rst_n = 1'b0;
   logic [ADDR_W-1:0] addr;
   logic [7:0]        wdata;
   logic              wr;
   logic              rd;
   lias_live_t        live [NCH];
   lias_evt_t         evt  [NCH];
   logic              count_tick = 1'b0;
   logic [7:0]        rdata;
   logic              irq;
   logic [7:0]        got;
   logic [7:0]        fmask;
   logic [7:0]        esel;
   logic [15:0]       cnt;
   int                ch;
   int                num_errors = 0;
   int                checks_done = 0;
   int                fb [5] = '{B1_SYS_ALARM, B1_LINE_ALARM, B1_PATTERN,
                                 B1_LOOP_ACT, B1_LOOP_DEACT};
   int                sb [5] = '{BE_ALARM, BE_ALARM, BE_PATTERN, BE_LOOP_CODE, BE_LOOP_CODE};

   always #20 mclk = ~mclk;

   initial begin
      for (int c = 0; c < NCH; c++) begin
         live[c] = '0;
         evt[c]  = '0;
      end
   end

   lias_top #(.NUM_CH(NCH)) i_lias_top (
      .i_mclk       (mclk),
      .i_rst_n      (rst_n),
      .i_addr       (addr),
      .i_wdata      (wdata),
      .i_wr         (wr),
      .i_rd         (rd),
      .i_live       (live),
      .i_evt        (evt),
      .i_count_tick (count_tick),
      .o_rdata      (rdata),
      .o_irq        (irq)
   );

   lias_host i_lias_host (
      .i_mclk  (mclk),
      .i_rdata (rdata),
      .o_addr  (addr),
      .o_wdata (wdata),
      .o_wr    (wr),
      .o_rd    (rd)
   );

   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   function automatic logic [ADDR_W-1:0] reg_addr(input int c, input logic [5:0] ofs);
      return {c[4:0], ofs};
   endfunction : reg_addr

   task automatic check(input logic [7:0] g, input logic [7:0] e, input string what);
      checks_done++;
      if (g !== e) begin
         num_errors++;
         $display("Error %0t: %s got %h expected %h", $time, what, g, e);
      end
   endtask : check

   task automatic rd_chk(input int c, input logic [5:0] ofs, input logic [7:0] e,
                         input string what);
      i_lias_host.bus_read(reg_addr(c, ofs), got);
      check(got, e, what);
   endtask : rd_chk

   task automatic wait_clk(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : wait_clk

   task automatic pulse_evt(input int c, input logic [5:0] v, input int n);
      @(posedge mclk);
      evt[c] <= lias_evt_t'(v);
      repeat (n) @(posedge mclk);
      evt[c] <= '0;
   endtask : pulse_evt

   task automatic finish_test;
      $display("checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : finish_test

   initial begin
      repeat (100000) @(posedge mclk);
      num_errors++;
      $display("Error %0t: run timed out", $time);
      finish_test();
   end

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (5) @(posedge mclk);
      rst_n <= 1'b1;
      wait_clk(3);
      check({7'h00, irq}, 8'h00, "irq after reset");
      rd_chk(0, OFS_FLAGS1, 8'h00, "flags1 reset");
      rd_chk(14, OFS_FLAGS2, 8'h00, "flags2 reset");
      rd_chk(0, OFS_CNT_LO, 8'h00, "count low reset");
      rd_chk(15, OFS_FLAGS1, 8'h00, "absent channel");
      $display("test reset done");

      // each live bit, rising only and then any edge
      for (int k = 0; k < 5; k++) begin
         for (int s = 0; s < 2; s++) begin
            ch = 3 * k + s;
            fmask = 8'h01 << fb[k];
            esel = s ? (8'h01 << sb[k]) : 8'h00;
            i_lias_host.bus_write(reg_addr(ch, OFS_EDGE_SEL), esel);
            rd_chk(ch, OFS_EDGE_SEL, esel, "edge select readback");
            @(posedge mclk);
            live[ch][4-k] <= 1'b1;
            wait_clk(3);
            check({7'h00, irq}, 8'h01, "irq on rise");
            rd_chk(ch, OFS_FLAGS1, fmask, "rise flag");
            i_lias_host.bus_write(reg_addr(ch, OFS_FLAGS1), fmask);
            rd_chk(ch, OFS_FLAGS1, 8'h00, "flag cleared");
            @(posedge mclk);
            live[ch][4-k] <= 1'b0;
            wait_clk(3);
            rd_chk(ch, OFS_FLAGS1, s ? fmask : 8'h00, "fall flag");
            i_lias_host.bus_write(reg_addr(ch, OFS_FLAGS1), 8'hFF);
            wait_clk(3);
            check({7'h00, irq}, 8'h00, "irq released");
         end
      end
      $display("test edges done");

      // each latched event in its own position
      for (int b = 5; b >= 1; b--) begin
         pulse_evt(1, 6'h01 << b, 1);
         rd_chk(1, OFS_FLAGS2, 8'h01 << b, "event flag");
         i_lias_host.bus_write(reg_addr(1, OFS_FLAGS2), 8'h00);
         rd_chk(1, OFS_FLAGS2, 8'h01 << b, "zero write kept");
         i_lias_host.bus_write(reg_addr(1, OFS_FLAGS2), 8'hFF);
         rd_chk(1, OFS_FLAGS2, 8'h00, "event cleared");
      end
      pulse_evt(2, 6'h20, 1);
      fork
         i_lias_host.bus_write(reg_addr(2, OFS_FLAGS2), 8'h20);
         pulse_evt(2, 6'h20, 1);
      join
      rd_chk(2, OFS_FLAGS2, 8'h20, "set beats clear");
      i_lias_host.bus_write(reg_addr(2, OFS_FLAGS2), 8'h20);
      $display("test events done");

      // manual capture, automatic capture, wrap
      i_lias_host.bus_write(reg_addr(4, OFS_ERR_CFG), 8'h01);
      pulse_evt(4, 6'h01, 261);
      i_lias_host.bus_write(reg_addr(4, OFS_ERR_CFG), 8'h01);
      i_lias_host.read_count(5'd4, cnt);
      check(cnt[7:0], 8'h05, "manual low");
      check(cnt[15:8], 8'h01, "manual high");
      i_lias_host.bus_write(reg_addr(4, OFS_ERR_CFG), 8'h02);
      rd_chk(4, OFS_ERR_CFG, 8'h02, "mode readback");
      pulse_evt(4, 6'h01, 3);
      @(posedge mclk);
      count_tick <= 1'b1;
      @(posedge mclk);
      count_tick <= 1'b0;
      i_lias_host.read_count(5'd4, cnt);
      check(cnt[7:0], 8'h03, "auto low");
      check(cnt[15:8], 8'h00, "auto high");
      i_lias_host.bus_write(reg_addr(4, OFS_ERR_CFG), 8'h00);
      i_lias_host.bus_write(reg_addr(4, OFS_ERR_CFG), 8'h01);
      pulse_evt(4, 6'h01, 65535);
      rd_chk(4, OFS_FLAGS2, 8'h00, "no early wrap");
      pulse_evt(4, 6'h01, 1);
      wait_clk(2);
      check({7'h00, irq}, 8'h01, "irq on wrap");
      rd_chk(4, OFS_FLAGS2, 8'h01, "wrap flag");
      i_lias_host.bus_write(reg_addr(4, OFS_FLAGS2), 8'h01);
      wait_clk(3);
      check({7'h00, irq}, 8'h00, "irq after wrap clear");
      $display("test counter done");
      finish_test();
   end
endmodule : lias_top_test
